// ### core/mps_motor_param_store.sv
// Operation-data and parameter store with power-up load and batch commit to non-volatile memory.
`timescale 1ns/1ns
//
// Overview of operation
// - Sixteen operation-data entries, each with speed, acceleration, deceleration and torque limit.
// - At power-up copy non-volatile memory into working memory, then run setup.
// - Working memory is lost on reset; non-volatile copy is kept unchanged.
// - Port writes change working memory only, never the non-volatile copy.
// - Batch commit command copies all working words into non-volatile memory.
// - Class A values act at once, with recalculation right after the write.
// - Class B values are applied at power-up, and otherwise only once the motor has stopped.
// - Class C values apply on the configuration command or at power-up.
// - Class D values apply only at power-up; no command applies them.
// - Speed accepts 100-4000 analog, 80-4000 digital; resets to zero.
// - Acceleration accepts 0.2-15 s, resets to 0.5 s, acts at once.
// - Each entry keeps its own deceleration time.
// - Ramps refer to the set speed when digital, to 3000 r/min when analog.
// - Each entry holds a torque limit relative to rated torque, reset 200.
// - Speed source selectable between analog input and digital value.
// - Four select inputs pick the entry; entries 8-15 use digital speed only.
// - Busy output is high while a maintenance command is processed.
module mps_motor_param_store import mps_pkg::*; #(
	parameter int NV_ADDR_W = NV_AW
) (
	input logic clock,
	input logic reset,
	input logic ce,
	input logic [AW-1:0] addr,
	input logic [DW-1:0] wdata,
	input logic wr_strobe,
	input logic rd_strobe,
	output logic [DW-1:0] rdata,
	input logic entry_select_bit0,
	input logic entry_select_bit1,
	input logic entry_select_bit2,
	input logic entry_select_bit3,
	input logic motor_running,
	output logic internal_busy_out,
	output logic recalc_pulse,
	output logic [DW-1:0] active_speed,
	output logic [DW-1:0] active_accel,
	output logic [DW-1:0] active_decel,
	output logic [DW-1:0] active_torque,
	output logic [DW-1:0] ramp_ref_speed,
	output logic analog_speed_active,
	output logic [DW-1:0] param_a_eff,
	output logic [DW-1:0] param_b_eff,
	output logic [DW-1:0] param_c_eff,
	output logic [DW-1:0] param_d_eff
);

	// Range check of a written value; speed limits depend on the entry's speed source.
	function automatic logic value_ok(input logic [6:0] idx, input logic [DW-1:0] val, input logic digital);
		logic [DW-1:0] smin;
		smin = (digital || idx[5]) ? SPEED_MIN_DIG : SPEED_MIN_ANA;
		if (idx[6])
			return 1'b1;
		case (idx[1:0])
			FLD_SPEED: return (val >= smin) && (val <= SPEED_MAX);
			FLD_TORQUE: return val <= TORQUE_MAX;
			default: return (val >= RAMP_MIN) && (val <= RAMP_MAX);
		endcase
	endfunction : value_ok

	mps_state_e state_reg;
	mps_state_e state_next;
	logic [6:0] cnt_reg;
	logic load_valid_reg;
	logic [6:0] load_idx_reg;
	logic [DW-1:0] work_reg [0:N_WORDS-1];
	logic speed_digital_reg;
	logic reject_reg;
	logic b_pend_reg;
	logic c_pend_reg;
	logic [3:0] sel_reg;
	logic [DW-1:0] rdata_reg;
	logic busy_reg;
	logic recalc_reg;
	logic [DW-1:0] speed_reg;
	logic [DW-1:0] accel_reg;
	logic [DW-1:0] decel_reg;
	logic [DW-1:0] torque_reg;
	logic [DW-1:0] ramp_ref_reg;
	logic analog_reg;
	logic [DW-1:0] a_eff_reg;
	logic [DW-1:0] b_eff_reg;
	logic [DW-1:0] c_eff_reg;
	logic [DW-1:0] d_eff_reg;
	logic [DW-1:0] nv_rdata;

	// Port decode: working words are writable only while the store is idle.
	wire [3:0] sel = {entry_select_bit3, entry_select_bit2, entry_select_bit1, entry_select_bit0};
	wire in_idle = (state_reg == ST_IDLE);
	wire [6:0] widx = addr[6:0];
	wire wr_work = wr_strobe && (addr < ADDR_EFF_A);
	wire wr_valid = value_ok(widx, wdata, speed_digital_reg);
	wire wr_ok = wr_work && in_idle && wr_valid;
	wire wr_bad = wr_work && !(in_idle && wr_valid);
	wire cmd_hit = wr_strobe && (addr == ADDR_CMD) && in_idle;
	wire cmd_save = cmd_hit && wdata[CMD_SAVE_BIT];
	wire cmd_cfg = cmd_hit && wdata[CMD_CFG_BIT] && !wdata[CMD_SAVE_BIT];
	wire reject_clr = wr_strobe && (addr == ADDR_STATUS) && wdata[STAT_REJECT_BIT];
	wire setup_done = (state_reg == ST_SETUP) && !load_valid_reg;
	wire b_apply = in_idle && b_pend_reg && !motor_running;
	wire wr_class_a = wr_ok && (word_class(widx) == CLS_A);
	wire wr_class_b = wr_ok && (word_class(widx) == CLS_B);
	wire wr_class_c = wr_ok && (word_class(widx) == CLS_C);
	wire nv_we = (state_reg == ST_SAVE);
	wire [6:0] sel_base = {1'b0, sel, 2'b00};
	wire analog_next = !speed_digital_reg && !sel[3];
	wire [DW-1:0] sel_speed = work_reg[sel_base | {5'h00, FLD_SPEED}];
	wire [DW-1:0] status_word = {12'h000, c_pend_reg, b_pend_reg, reject_reg, busy_reg};

	// Read multiplexer for the register port.
	wire [DW-1:0] rd_mux = (addr < ADDR_EFF_A) ? work_reg[widx] :
		(addr == ADDR_EFF_A) ? a_eff_reg :
		(addr == ADDR_EFF_B) ? b_eff_reg :
		(addr == ADDR_EFF_C) ? c_eff_reg :
		(addr == ADDR_EFF_D) ? d_eff_reg :
		(addr == ADDR_CTRL) ? {15'h0000, speed_digital_reg} :
		(addr == ADDR_STATUS) ? status_word :
		(addr == ADDR_ACTIVE) ? {12'h000, sel_reg} : 16'h0000;

	// Sequencer: load after reset, setup, idle, and batch commit on command.
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ST_LOAD: if (cnt_reg == IDX_LAST) state_next = ST_SETUP;
			ST_SETUP: if (!load_valid_reg) state_next = ST_IDLE;
			ST_IDLE: if (cmd_save) state_next = ST_SAVE;
			ST_SAVE: if (cnt_reg == IDX_LAST) state_next = ST_IDLE;
			default: state_next = ST_LOAD;
		endcase
	end

	// Word counter shared by load and commit; the read pipeline lags it by one cycle.
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			state_reg <= ST_LOAD;
			cnt_reg <= 7'h00;
			load_valid_reg <= 1'b0;
			load_idx_reg <= 7'h00;
		end
		else if (ce)
		begin
			state_reg <= state_next;
			cnt_reg <= (state_next != state_reg) ? 7'h00 : cnt_reg + 7'h01;
			load_valid_reg <= (state_reg == ST_LOAD);
			load_idx_reg <= cnt_reg;
		end
	end

	// Working memory: cleared to reset values, filled from the non-volatile copy, then written by the port.
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			for (int i = 0; i < N_WORDS; i++)
				work_reg[i] <= word_reset(7'(i));
		end
		else if (ce)
		begin
			if (load_valid_reg)
				work_reg[load_idx_reg] <= nv_rdata;
			else if (wr_ok)
				work_reg[widx] <= wdata;
		end
	end

	// Non-volatile copy is written only during a batch commit.
	mps_nv_mem #(
		.DW(DW),
		.AW(NV_ADDR_W)
	) u_nv (
		.clock(clock),
		.ce(ce),
		.we(nv_we),
		.waddr(NV_ADDR_W'(cnt_reg)),
		.wdata(work_reg[cnt_reg]),
		.raddr(NV_ADDR_W'(cnt_reg)),
		.rdata(nv_rdata)
	);

	// Control and status flags; a refusal in the same cycle as its clear stays set.
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			speed_digital_reg <= 1'b0;
			reject_reg <= 1'b0;
			b_pend_reg <= 1'b0;
			c_pend_reg <= 1'b0;
		end
		else if (ce)
		begin
			if (wr_strobe && (addr == ADDR_CTRL))
				speed_digital_reg <= wdata[CTRL_DIGITAL_BIT];
			reject_reg <= (reject_reg && !reject_clr) || wr_bad;
			b_pend_reg <= (b_pend_reg && !b_apply && !setup_done) || wr_class_b;
			c_pend_reg <= (c_pend_reg && !cmd_cfg && !setup_done) || wr_class_c;
		end
	end

	// Effective parameter copies; each class moves only at its own trigger.
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			a_eff_reg <= PARAM_RST;
			b_eff_reg <= PARAM_RST;
			c_eff_reg <= PARAM_RST;
			d_eff_reg <= PARAM_RST;
		end
		else if (ce)
		begin
			a_eff_reg <= work_reg[IDX_PARAM_A];
			if (setup_done || b_apply)
				b_eff_reg <= work_reg[IDX_PARAM_B];
			if (setup_done || cmd_cfg)
				c_eff_reg <= work_reg[IDX_PARAM_C];
			if (setup_done)
				d_eff_reg <= work_reg[IDX_PARAM_D];
		end
	end

	// Active entry outputs follow the working copy at once, since all operation data are class A.
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			sel_reg <= 4'h0;
			speed_reg <= SPEED_RST;
			accel_reg <= RAMP_RST;
			decel_reg <= RAMP_RST;
			torque_reg <= TORQUE_RST;
			ramp_ref_reg <= RATED_SPEED;
			analog_reg <= 1'b1;
		end
		else if (ce)
		begin
			sel_reg <= sel;
			speed_reg <= sel_speed;
			accel_reg <= work_reg[sel_base | {5'h00, FLD_ACCEL}];
			decel_reg <= work_reg[sel_base | {5'h00, FLD_DECEL}];
			torque_reg <= work_reg[sel_base | {5'h00, FLD_TORQUE}];
			ramp_ref_reg <= analog_next ? RATED_SPEED : sel_speed;
			analog_reg <= analog_next;
		end
	end

	// Port read data, busy and recalculation strobe.
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			rdata_reg <= 16'h0000;
			busy_reg <= 1'b1;
			recalc_reg <= 1'b0;
		end
		else if (ce)
		begin
			rdata_reg <= rd_strobe ? rd_mux : 16'h0000;
			busy_reg <= (state_next != ST_IDLE);
			recalc_reg <= setup_done || wr_class_a || b_apply || cmd_cfg;
		end
	end

	assign rdata = rdata_reg;
	assign internal_busy_out = busy_reg;
	assign recalc_pulse = recalc_reg;
	assign active_speed = speed_reg;
	assign active_accel = accel_reg;
	assign active_decel = decel_reg;
	assign active_torque = torque_reg;
	assign ramp_ref_speed = ramp_ref_reg;
	assign analog_speed_active = analog_reg;
	assign param_a_eff = a_eff_reg;
	assign param_b_eff = b_eff_reg;
	assign param_c_eff = c_eff_reg;
	assign param_d_eff = d_eff_reg;

	// Checks on the store's own behaviour.
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);

	property p_save_busy;
		(ce && cmd_save) |=> internal_busy_out && nv_we;
	endproperty
	a_save_busy: assert property (p_save_busy) else $error("Commit did not start busy.");

	property p_port_no_nv;
		(ce && in_idle && !cmd_save) |=> !nv_we;
	endproperty
	a_port_no_nv: assert property (p_port_no_nv) else $error("Non-volatile write outside commit.");

	property p_reject_keeps;
		(ce && wr_bad && !load_valid_reg) |=> reject_reg && (work_reg[$past(widx)] == $past(work_reg[widx]));
	endproperty
	a_reject_keeps: assert property (p_reject_keeps) else $error("Refused write changed a word.");

	property p_a_now;
		(ce && wr_ok && (addr == ADDR_PARAM_A)) ##1 ce |=> param_a_eff == $past(wdata, 2);
	endproperty
	a_a_now: assert property (p_a_now) else $error("Class A value not effective.");

	property p_b_hold;
		(ce && in_idle && motor_running) |=> $stable(param_b_eff);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("Class B changed while running.");

	property p_b_apply;
		(ce && b_apply) |=> param_b_eff == $past(work_reg[IDX_PARAM_B]) && recalc_pulse;
	endproperty
	a_b_apply: assert property (p_b_apply) else $error("Class B not applied at stop.");

	property p_c_cfg;
		(ce && cmd_cfg) |=> param_c_eff == $past(work_reg[IDX_PARAM_C]) && !c_pend_reg;
	endproperty
	a_c_cfg: assert property (p_c_cfg) else $error("Class C not applied by configuration.");

	property p_d_hold;
		(ce && in_idle) |=> $stable(param_d_eff);
	endproperty
	a_d_hold: assert property (p_d_hold) else $error("Class D changed without power-up.");

	property p_setup;
		(ce && setup_done) |=> recalc_pulse && !internal_busy_out;
	endproperty
	a_setup: assert property (p_setup) else $error("Setup after load missing.");

	property p_sel_digital;
		(ce && entry_select_bit3) |=> !analog_speed_active;
	endproperty
	a_sel_digital: assert property (p_sel_digital) else $error("Upper entry used analog speed.");

	property p_ramp_ref;
		(ce && !entry_select_bit3 && !speed_digital_reg) |=> ramp_ref_speed == RATED_SPEED;
	endproperty
	a_ramp_ref: assert property (p_ramp_ref) else $error("Analog ramp reference wrong.");

	property p_cov_save;
		(state_reg == ST_SAVE) ##1 in_idle;
	endproperty
	c_save: cover property (p_cov_save);

	property p_cov_b;
		b_apply;
	endproperty
	c_b: cover property (p_cov_b);

	property p_cov_reject;
		wr_bad ##1 reject_clr;
	endproperty
	c_reject: cover property (p_cov_reject);

endmodule : mps_motor_param_store

// ### core/mps_nv_mem.sv
// Non-volatile parameter memory model with registered read data.
`timescale 1ns/1ns
module mps_nv_mem #(
	parameter int DW = 16,
	parameter int AW = 7
) (
	input logic clock,
	input logic ce,
	input logic we,
	input logic [AW-1:0] waddr,
	input logic [DW-1:0] wdata,
	input logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata
);

	logic [DW-1:0] mem_reg [0:(2**AW)-1];
	logic [DW-1:0] rdata_reg;

	// The array has no reset on purpose: its contents outlive any reset of the store.
	always_ff @(posedge clock)
	begin
		if (ce)
		begin
			if (we)
				mem_reg[waddr] <= wdata;
			rdata_reg <= mem_reg[raddr];
		end
	end

	assign rdata = rdata_reg;

endmodule : mps_nv_mem

// ### shared/mps_pkg.sv
// Constants, types and helper functions shared by the motor parameter store.
package mps_pkg;

	localparam int DW = 16;
	localparam int AW = 8;
	localparam int NV_AW = 7;
	localparam int N_ENTRY = 16;
	localparam int N_WORDS = 68;

	// Word index layout: entry * 4 + field for operation data, then four user parameters.
	localparam logic [1:0] FLD_SPEED = 2'h0;
	localparam logic [1:0] FLD_ACCEL = 2'h1;
	localparam logic [1:0] FLD_DECEL = 2'h2;
	localparam logic [1:0] FLD_TORQUE = 2'h3;
	localparam logic [6:0] IDX_PARAM_A = 7'h40;
	localparam logic [6:0] IDX_PARAM_B = 7'h41;
	localparam logic [6:0] IDX_PARAM_C = 7'h42;
	localparam logic [6:0] IDX_PARAM_D = 7'h43;
	localparam logic [6:0] IDX_LAST = 7'h43;

	// Register port addresses.
	localparam logic [AW-1:0] ADDR_PARAM_A = 8'h40;
	localparam logic [AW-1:0] ADDR_EFF_A = 8'h44;
	localparam logic [AW-1:0] ADDR_EFF_B = 8'h45;
	localparam logic [AW-1:0] ADDR_EFF_C = 8'h46;
	localparam logic [AW-1:0] ADDR_EFF_D = 8'h47;
	localparam logic [AW-1:0] ADDR_CTRL = 8'h48;
	localparam logic [AW-1:0] ADDR_CMD = 8'h49;
	localparam logic [AW-1:0] ADDR_STATUS = 8'h4a;
	localparam logic [AW-1:0] ADDR_ACTIVE = 8'h4b;

	// Bit positions.
	localparam int CTRL_DIGITAL_BIT = 0;
	localparam int CMD_SAVE_BIT = 0;
	localparam int CMD_CFG_BIT = 1;
	localparam int STAT_REJECT_BIT = 1;

	// Reset values and ranges; ramp times are in 0.1 s units, torque in percent of rated.
	localparam logic [DW-1:0] SPEED_RST = 16'h0000;
	localparam logic [DW-1:0] RAMP_RST = 16'h0005;
	localparam logic [DW-1:0] TORQUE_RST = 16'h00c8;
	localparam logic [DW-1:0] PARAM_RST = 16'h0000;
	localparam logic [DW-1:0] SPEED_MIN_ANA = 16'h0064;
	localparam logic [DW-1:0] SPEED_MIN_DIG = 16'h0050;
	localparam logic [DW-1:0] SPEED_MAX = 16'h0fa0;
	localparam logic [DW-1:0] RAMP_MIN = 16'h0002;
	localparam logic [DW-1:0] RAMP_MAX = 16'h0096;
	localparam logic [DW-1:0] TORQUE_MAX = 16'h00c8;
	localparam logic [DW-1:0] RATED_SPEED = 16'h0bb8;

	typedef enum logic [1:0] {CLS_A = 2'h0, CLS_B = 2'h1, CLS_C = 2'h2, CLS_D = 2'h3} mps_class_e;

	typedef enum logic [3:0] {
		ST_LOAD = 4'b0001,
		ST_SETUP = 4'b0010,
		ST_IDLE = 4'b0100,
		ST_SAVE = 4'b1000
	} mps_state_e;

	// Fixed update class of each word; all operation data act at once.
	function automatic mps_class_e word_class(input logic [6:0] idx);
		if (!idx[6])
			return CLS_A;
		return mps_class_e'(idx[1:0]);
	endfunction : word_class

	// Value that a word takes at reset.
	function automatic logic [DW-1:0] word_reset(input logic [6:0] idx);
		if (idx[6])
			return PARAM_RST;
		case (idx[1:0])
			FLD_SPEED: return SPEED_RST;
			FLD_TORQUE: return TORQUE_RST;
			default: return RAMP_RST;
		endcase
	endfunction : word_reset

endpackage : mps_pkg

// ### test/mps_host_model.sv
// Serial-link master model that drives the register port of the parameter store.
`timescale 1ns/1ns
module mps_host_model import mps_pkg::*; (
	input logic clock,
	output logic [AW-1:0] addr,
	output logic [DW-1:0] wdata,
	output logic wr_strobe,
	output logic rd_strobe,
	input logic [DW-1:0] rdata
);

	// The bus is idle from time zero so no stray strobe reaches the store.
	initial
	begin
		addr = '0;
		wdata = '0;
		wr_strobe = 1'b0;
		rd_strobe = 1'b0;
	end

	// One-cycle write; address and data are inverted once released so nothing leans on stale values.
	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr_strobe <= 1'b1;
		@(posedge clock);
		wr_strobe <= 1'b0;
		addr <= ~a;
		wdata <= ~d;
	endtask : wr

	// One-cycle read; the data stand only in the cycle after the strobe, so they are taken there.
	task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
		@(posedge clock);
		addr <= a;
		rd_strobe <= 1'b1;
		@(posedge clock);
		rd_strobe <= 1'b0;
		addr <= ~a;
		@(negedge clock);
		d = rdata;
	endtask : rd

	// The host commits only before power goes, because the store wears out with every commit.
	task automatic commit_all();
		wr(ADDR_CMD, 16'h0001);
	endtask : commit_all

endmodule : mps_host_model

// ### test/tb_top.sv
// Self-checking testbench for the motor parameter store.
`timescale 1ns/1ns
module tb_top import mps_pkg::*;;

	logic clock = 1'b0;
	logic reset = 1'b1;
	logic ce = 1'b1;
	logic [3:0] sel = 4'h0;
	logic motor_running = 1'b0;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata, rdata;
	logic wr_strobe, rd_strobe, internal_busy_out, recalc_pulse, analog_speed_active;
	logic [DW-1:0] active_speed, active_accel, active_decel, active_torque, ramp_ref_speed;
	logic [DW-1:0] param_a_eff, param_b_eff, param_c_eff, param_d_eff;
	logic [DW-1:0] exp_w [N_WORDS];
	int n_mismatch = 0;
	int cmp_count = 0;

	// Free-running 250 MHz clock.
	always #2 clock = ~clock;

	mps_host_model host (.clock(clock), .addr(addr), .wdata(wdata), .wr_strobe(wr_strobe),
		.rd_strobe(rd_strobe), .rdata(rdata));

	mps_motor_param_store DUT (.clock(clock), .reset(reset), .ce(ce), .addr(addr), .wdata(wdata),
		.wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata), .entry_select_bit0(sel[0]),
		.entry_select_bit1(sel[1]), .entry_select_bit2(sel[2]), .entry_select_bit3(sel[3]),
		.motor_running(motor_running), .internal_busy_out(internal_busy_out), .recalc_pulse(recalc_pulse),
		.active_speed(active_speed), .active_accel(active_accel), .active_decel(active_decel),
		.active_torque(active_torque), .ramp_ref_speed(ramp_ref_speed), .analog_speed_active(analog_speed_active),
		.param_a_eff(param_a_eff), .param_b_eff(param_b_eff), .param_c_eff(param_c_eff), .param_d_eff(param_d_eff));

	// Comparisons of words and of single flags.
	task automatic chk_w(input string what, input logic [DW-1:0] e, input logic [DW-1:0] g);
		cmp_count++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask : chk_w

	task automatic chk_b(input string what, input logic e, input logic g);
		cmp_count++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %b seen %b", what, e, g);
		end
	endtask : chk_b

	// Outputs are looked at on the falling edge, where the rising edge's updates have landed.
	task automatic settle(input int n);
		repeat (n) @(posedge clock);
		@(negedge clock);
	endtask : settle

	task automatic rd_chk(input string what, input logic [AW-1:0] a, input logic [DW-1:0] e);
		logic [DW-1:0] d;
		host.rd(a, d);
		chk_w(what, e, d);
	endtask : rd_chk

	// Reset for 20 cycles, checking the reset values of the outputs midway.
	task automatic do_reset();
		@(posedge clock);
		reset <= 1'b1;
		settle(10);
		chk_w("rst speed", 16'h0000, active_speed);
		chk_w("rst accel", 16'h0005, active_accel);
		chk_w("rst torque", 16'h00c8, active_torque);
		chk_w("rst ramp ref", 16'h0bb8, ramp_ref_speed);
		chk_b("rst busy", 1'b1, internal_busy_out);
		repeat (10) @(posedge clock);
		reset <= 1'b0;
	endtask : do_reset

	// The load after reset is bounded, so a stuck busy flag ends the wait as a mismatch.
	task automatic wait_idle();
		int i;
		i = 0;
		while (internal_busy_out !== 1'b0 && i < 300)
		begin
			@(negedge clock);
			i++;
		end
		chk_b("busy", 1'b0, internal_busy_out);
	endtask : wait_idle

	task automatic s_fill();
		for (int e = 0; e < N_ENTRY; e++)
		begin
			exp_w[4*e] = 16'(100 + 100*e);
			exp_w[4*e+1] = 16'(2 + e);
			exp_w[4*e+2] = 16'(20 + e);
			exp_w[4*e+3] = 16'(100 + e);
		end
		for (int i = 0; i < 4; i++)
			exp_w[64+i] = 16'(11*(i+1));
		for (int i = 0; i < N_WORDS; i++)
			host.wr(8'(i), exp_w[i]);
		for (int i = 0; i < N_WORDS; i++)
			rd_chk("word", 8'(i), exp_w[i]);
		// Commit and power up again so that the effective copies hold known values, not the blank memory.
		host.commit_all();
		settle(1);
		wait_idle();
		do_reset();
		wait_idle();
		chk_w("eff c load", 16'h0021, param_c_eff);
		chk_w("eff d load", 16'h002c, param_d_eff);
	endtask : s_fill

	task automatic s_select();
		logic [3:0] es [4] = '{4'h0, 4'h7, 4'h8, 4'hf};
		logic [3:0] e;
		for (int k = 0; k < 4; k++)
		begin
			e = es[k];
			@(posedge clock);
			sel <= e;
			settle(2);
			chk_w("speed", exp_w[4*e], active_speed);
			chk_w("accel", exp_w[4*e+1], active_accel);
			chk_w("decel", exp_w[4*e+2], active_decel);
			chk_w("torque", exp_w[4*e+3], active_torque);
			chk_b("analog", ~e[3], analog_speed_active);
			chk_w("ramp ref", e[3] ? exp_w[4*e] : 16'h0bb8, ramp_ref_speed);
			rd_chk("active no", ADDR_ACTIVE, {12'h000, e});
		end
		// A lower entry is chosen, so only the control bit can make the speed digital.
		@(posedge clock);
		sel <= 4'h0;
		host.wr(ADDR_CTRL, 16'h0001);
		host.wr(8'h00, 16'h0050);
		exp_w[0] = 16'h0050;
		rd_chk("digital speed", 8'h00, 16'h0050);
		settle(2);
		chk_b("analog", 1'b0, analog_speed_active);
		chk_w("ramp ref", 16'h0050, ramp_ref_speed);
		host.wr(ADDR_CTRL, 16'h0000);
	endtask : s_select

	// Boundary values; speed on the upper entries is digital even while analog is chosen.
	task automatic s_ranges();
		logic [7:0] ta [9] = '{8'h20, 8'h20, 8'h00, 8'h00, 8'h01, 8'h02, 8'h03, 8'h03, 8'h04};
		logic [15:0] tv [9] = '{16'h004f, 16'h0050, 16'h0063, 16'h0064, 16'h0001, 16'h0096, 16'h00c9,
			16'h00c8, 16'h0fa1};
		logic [8:0] ok = 9'b010101010;
		logic [15:0] d;
		for (int k = 0; k < 9; k++)
		begin
			host.wr(ta[k], tv[k]);
			if (ok[k])
				exp_w[ta[k]] = tv[k];
			rd_chk("ranged word", ta[k], exp_w[ta[k]]);
			host.rd(ADDR_STATUS, d);
			chk_b("reject", ~ok[k], d[STAT_REJECT_BIT]);
			host.wr(ADDR_STATUS, 16'h0002);
		end
	endtask : s_ranges

	task automatic s_class();
		logic seen;
		seen = 1'b0;
		exp_w[64] = 16'h1111;
		exp_w[65] = 16'h2222;
		exp_w[66] = 16'h3333;
		exp_w[67] = 16'h4444;
		host.wr(ADDR_PARAM_A, 16'h1111);
		repeat (3)
		begin
			@(negedge clock);
			seen = seen | recalc_pulse;
		end
		chk_b("recalc", 1'b1, seen);
		chk_w("eff a", 16'h1111, param_a_eff);
		@(posedge clock);
		motor_running <= 1'b1;
		host.wr(ADDR_PARAM_A + 8'h01, 16'h2222);
		settle(4);
		chk_w("eff b held", 16'h0016, param_b_eff);
		@(posedge clock);
		motor_running <= 1'b0;
		settle(3);
		chk_w("eff b", 16'h2222, param_b_eff);
		host.wr(ADDR_PARAM_A + 8'h02, 16'h3333);
		host.wr(ADDR_PARAM_A + 8'h03, 16'h4444);
		settle(3);
		chk_w("eff c held", 16'h0021, param_c_eff);
		host.wr(ADDR_CMD, 16'h0002);
		settle(3);
		chk_w("eff c", 16'h3333, param_c_eff);
		chk_w("eff d held", 16'h002c, param_d_eff);
	endtask : s_class

	// A commit, a refused write while busy, an uncommitted change, then power comes back.
	task automatic s_commit();
		host.commit_all();
		settle(2);
		chk_b("busy", 1'b1, internal_busy_out);
		host.wr(8'h04, 16'h0200);
		wait_idle();
		rd_chk("busy write", 8'h04, exp_w[4]);
		host.wr(8'h08, 16'h0300);
		rd_chk("working", 8'h08, 16'h0300);
		do_reset();
		wait_idle();
		for (int i = 0; i < N_WORDS; i++)
			rd_chk("reloaded", 8'(i), exp_w[i]);
		chk_w("eff c", 16'h3333, param_c_eff);
		chk_w("eff d", 16'h4444, param_d_eff);
	endtask : s_commit

	task automatic s_unmapped();
		host.wr(8'h80, 16'hffff);
		rd_chk("unmapped", 8'h80, 16'h0000);
		host.wr(ADDR_EFF_A, 16'h5555);
		rd_chk("eff a", ADDR_EFF_A, 16'h1111);
		// With the clock enable low a legal write must leave no trace.
		@(posedge clock);
		ce <= 1'b0;
		host.wr(8'h05, 16'h0010);
		@(posedge clock);
		ce <= 1'b1;
		rd_chk("frozen write", 8'h05, exp_w[5]);
	endtask : s_unmapped

	task automatic print_verdict();
		if (n_mismatch == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : print_verdict

	// Main sequence.
	initial
	begin
		do_reset();
		wait_idle();
		s_fill();
		s_select();
		s_ranges();
		s_class();
		s_commit();
		s_unmapped();
		print_verdict();
	end

	// Watchdog; the sequence needs about one thousand cycles, so this margin only cuts a hang.
	initial
	begin
		repeat (20000) @(posedge clock);
		n_mismatch++;
		print_verdict();
	end

endmodule : tb_top
